// >>> hw/acc_pkg.sv
// Package with register map, field positions and codes for the comparator control block
package acc_pkg;
	localparam int ACC_NUM_CMP = 3;
	// Register indices: printed offsets are not all multiples of four, so byte address is index times four
	localparam logic [11:0] ACC_IDX_CTRL3  = 12'hf25;
	localparam logic [11:0] ACC_IDX_STATUS = 12'hf70;
	localparam logic [11:0] ACC_IDX_CTRL2  = 12'hfd1;
	localparam logic [11:0] ACC_IDX_CTRL1  = 12'hfd2;
	localparam logic [11:0] ACC_IDX_FLAGS  = 12'hf80;
	localparam logic [11:0] ACC_IDX_IRQST  = 12'hf81;
	localparam logic [11:0] ACC_IDX_IRQMSK = 12'hf82;
	localparam logic [11:0] ACC_IDX_ENABLE = 12'hf83;
	localparam int ACC_ADDR_W = 14;
	// Control register fields
	localparam int ACC_BIT_ON     = 7;
	localparam int ACC_BIT_PINEN  = 6;
	localparam int ACC_BIT_INV    = 5;
	localparam int ACC_BIT_EVHI   = 4;
	localparam int ACC_BIT_EVLO   = 3;
	localparam int ACC_BIT_PLUS   = 2;
	localparam int ACC_BIT_MINUSH = 1;
	localparam int ACC_BIT_MINUSL = 0;
	localparam logic [7:0] ACC_CTRL_RESET = 8'h1f;
	// Flag register bit positions: comparator 1 in bit 5, comparator 2 in bit 6, 3 in bit 7
	localparam int ACC_FLAG_BASE = 5;
	typedef enum logic [1:0] {
		ACC_EV_NONE = 2'b00,
		ACC_EV_RISE = 2'b01,
		ACC_EV_FALL = 2'b10,
		ACC_EV_ANY  = 2'b11
	} acc_event_type;
	typedef enum logic [1:0] {
		ACC_MINUS_B    = 2'b00,
		ACC_MINUS_C    = 2'b01,
		ACC_MINUS_D    = 2'b10,
		ACC_MINUS_FIXD = 2'b11
	} acc_minus_type;
	localparam logic [1:0] ACC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] ACC_RESP_SLVERR = 2'b10;
endpackage

// >>> hw/acc_channel.sv
// One comparator channel: sync, polarity, edge detect and input selection
`timescale 1ns/1ps
`default_nettype none
module acc_channel
	import acc_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] ctrl,
	input  wire logic       raw_result,
	output logic            result,
	output logic            event_pulse,
	output logic            pin_out,
	output logic            pin_oe,
	output logic            plus_use_ladder,
	output logic [1:0]      minus_sel
);
	logic sync1_reg;
	logic sync2_reg;
	logic result_reg;
	logic mode_any_reg;
	logic adj;
	logic on;
	logic rise;
	logic fall;
	logic any_entry;
	acc_event_type mode;

	// Derived controls
	assign on              = ctrl[ACC_BIT_ON];
	assign adj             = on & (sync2_reg ^ ctrl[ACC_BIT_INV]);
	assign mode            = acc_event_type'({ctrl[ACC_BIT_EVHI], ctrl[ACC_BIT_EVLO]});
	assign rise            = ~result_reg & adj;
	assign fall            = result_reg & ~adj;
	assign any_entry       = (mode == ACC_EV_ANY) & ~mode_any_reg & on;
	assign plus_use_ladder = ctrl[ACC_BIT_PLUS];
	assign minus_sel       = {ctrl[ACC_BIT_MINUSH], ctrl[ACC_BIT_MINUSL]};
	assign result          = result_reg;
	assign pin_out         = result_reg & ctrl[ACC_BIT_PINEN];
	assign pin_oe          = on & ctrl[ACC_BIT_PINEN];

	// Event decode by edge select
	always_comb begin
		unique case (mode)
			ACC_EV_NONE: event_pulse = 1'b0;
			ACC_EV_RISE: event_pulse = rise;
			ACC_EV_FALL: event_pulse = fall;
			ACC_EV_ANY:  event_pulse = rise | fall | any_entry;
		endcase
	end

	// Two-stage sync then registered result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg    <= 1'b0;
			sync2_reg    <= 1'b0;
			result_reg   <= 1'b0;
			mode_any_reg <= 1'b0;
		end else begin
			sync1_reg    <= raw_result;
			sync2_reg    <= sync1_reg;
			result_reg   <= adj;
			mode_any_reg <= (mode == ACC_EV_ANY) & on;
		end
	end

	a_edge_sets_once: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == ACC_EV_RISE && !result_reg && adj) |-> event_pulse ##1 (result_reg && !rise))
		else $error("rise edge not flagged once");
	a_none_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == ACC_EV_NONE) |-> !event_pulse)
		else $error("event in disabled mode");
	a_fall_only: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == ACC_EV_FALL && event_pulse) |-> result_reg && !adj)
		else $error("fall event without fall");
	a_off_low: assert property (@(posedge aclk) disable iff (!aresetn)
		!on [*2] |-> !result_reg)
		else $error("result high while off");
endmodule
`default_nettype wire

// >>> hw/acc_top.sv
// Comparator control block top: AXI4-Lite registers, three channels, flags and interrupt
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module acc_top
	import acc_pkg::*;
#(
	parameter int NUM_CMP = ACC_NUM_CMP
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ACC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [NUM_CMP-1:0]    raw_result,
	output logic [NUM_CMP-1:0]         result_output_pin,
	output logic [NUM_CMP-1:0]         result_output_pin_oe,
	output logic [NUM_CMP-1:0]         plus_input_source,
	output logic [2*NUM_CMP-1:0]       minus_input_select,
	output logic [NUM_CMP-1:0]         comparator_on,
	output logic                       irq
);
	// Elaboration check: the address decode serves exactly the mapped channels
	if (NUM_CMP != ACC_NUM_CMP) begin : g_bad_count
		$error("NUM_CMP must equal the mapped comparator count");
	end

	logic [7:0] ctrl_reg [NUM_CMP];
	logic [NUM_CMP-1:0] flag_reg;
	logic [NUM_CMP-1:0] irq_stat_reg;
	logic [NUM_CMP-1:0] irq_mask_reg;
	logic [NUM_CMP-1:0] flag_en_reg;
	logic [NUM_CMP-1:0] result;
	logic [NUM_CMP-1:0] event_pulse;
	logic [NUM_CMP-1:0] pin_raw;
	logic [NUM_CMP-1:0] pin_oe_raw;
	logic [NUM_CMP-1:0] pin_reg;
	logic [NUM_CMP-1:0] pin_oe_reg;
	logic [ACC_ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Map a register index to a byte address
	function automatic logic [ACC_ADDR_W-1:0] idx_addr(input logic [11:0] idx);
		idx_addr = {idx, 2'b00};
	endfunction

	// Control register number for an address, or NUM_CMP if none
	function automatic int ctrl_sel(input logic [ACC_ADDR_W-1:0] a);
		if (a == idx_addr(ACC_IDX_CTRL1))
			ctrl_sel = 0;
		else if (a == idx_addr(ACC_IDX_CTRL2))
			ctrl_sel = 1;
		else if (a == idx_addr(ACC_IDX_CTRL3))
			ctrl_sel = 2;
		else
			ctrl_sel = ACC_NUM_CMP;
	endfunction

	// Comparator channels, each from its own control register
	for (genvar i = 0; i < NUM_CMP; i++) begin : g_ch
		acc_channel u_ch (
			.aclk            (aclk),
			.aresetn         (aresetn),
			.ctrl            (ctrl_reg[i]),
			.raw_result      (raw_result[i]),
			.result          (result[i]),
			.event_pulse     (event_pulse[i]),
			.pin_out         (pin_raw[i]),
			.pin_oe          (pin_oe_raw[i]),
			.plus_use_ladder (plus_input_source[i]),
			.minus_sel       (minus_input_select[2*i+1:2*i])
		);
		assign comparator_on[i] = ctrl_reg[i][ACC_BIT_ON];
	end

	// Write path handshake and decode
	logic         aw_have;
	logic         w_have;
	logic         do_write;
	logic [ACC_ADDR_W-1:0] wr_addr;
	logic [31:0]  wr_data;
	logic         wr_lane0;
	logic         wr_hit;
	int           wr_ctrl;
	assign aw_have       = aw_held_reg | s_axi_awvalid;
	assign w_have        = w_held_reg | s_axi_wvalid;
	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
	assign do_write      = aw_have & w_have & ~bvalid_reg;
	assign wr_addr       = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	assign wr_data       = w_held_reg ? wdata_reg : s_axi_wdata;
	assign wr_lane0      = w_held_reg ? wstrb_reg[0] : s_axi_wstrb[0];
	assign wr_ctrl       = ctrl_sel(wr_addr);
	assign wr_hit        = (wr_ctrl < NUM_CMP) | (wr_addr == idx_addr(ACC_IDX_FLAGS))
		| (wr_addr == idx_addr(ACC_IDX_IRQMSK)) | (wr_addr == idx_addr(ACC_IDX_ENABLE))
		| (wr_addr == idx_addr(ACC_IDX_STATUS)) | (wr_addr == idx_addr(ACC_IDX_IRQST));
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	// Flag register writes: zero clears, one simulates an event
	logic flag_wr;
	logic [NUM_CMP-1:0] flag_wdata;
	logic [NUM_CMP-1:0] flag_next;
	assign flag_wr    = do_write & wr_lane0 & (wr_addr == idx_addr(ACC_IDX_FLAGS));
	assign flag_wdata = wr_data[ACC_FLAG_BASE +: NUM_CMP];
	assign flag_next  = (flag_wr ? flag_wdata : flag_reg) | event_pulse;

	// Read path
	logic do_read;
	logic [ACC_ADDR_W-1:0] rd_addr;
	int   rd_ctrl;
	logic [31:0] rd_word;
	logic rd_hit;
	logic irqst_read;
	assign do_read       = s_axi_arvalid & ~rvalid_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign rd_addr       = s_axi_araddr;
	assign rd_ctrl       = ctrl_sel(rd_addr);
	assign rd_hit        = (rd_ctrl < NUM_CMP) | (rd_addr == idx_addr(ACC_IDX_STATUS))
		| (rd_addr == idx_addr(ACC_IDX_FLAGS)) | (rd_addr == idx_addr(ACC_IDX_IRQST))
		| (rd_addr == idx_addr(ACC_IDX_IRQMSK)) | (rd_addr == idx_addr(ACC_IDX_ENABLE));
	assign irqst_read    = do_read & (rd_addr == idx_addr(ACC_IDX_IRQST));
	always_comb begin
		rd_word = 32'h0000_0000;
		if (rd_ctrl < NUM_CMP)
			rd_word[7:0] = ctrl_reg[rd_ctrl];
		else if (rd_addr == idx_addr(ACC_IDX_STATUS))
			rd_word[NUM_CMP-1:0] = result;
		else if (rd_addr == idx_addr(ACC_IDX_FLAGS))
			rd_word[ACC_FLAG_BASE +: NUM_CMP] = flag_reg;
		else if (rd_addr == idx_addr(ACC_IDX_IRQST))
			rd_word[NUM_CMP-1:0] = irq_stat_reg;
		else if (rd_addr == idx_addr(ACC_IDX_IRQMSK))
			rd_word[NUM_CMP-1:0] = irq_mask_reg;
		else if (rd_addr == idx_addr(ACC_IDX_ENABLE))
			rd_word[NUM_CMP-1:0] = flag_en_reg;
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// Interrupt: sticky status set by enabled flags' events, read clears, set wins
	logic [NUM_CMP-1:0] irq_set;
	assign irq_set = event_pulse & flag_en_reg;
	assign irq     = |(irq_stat_reg & irq_mask_reg);
	assign result_output_pin    = pin_reg;
	assign result_output_pin_oe = pin_oe_reg;

	// Bus handshake state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= ACC_RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= ACC_RESP_OKAY;
		end else begin
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
			end else begin
				if (s_axi_awvalid & s_axi_awready) begin
					aw_held_reg <= 1'b1;
					awaddr_reg  <= s_axi_awaddr;
				end
				if (s_axi_wvalid & s_axi_wready) begin
					w_held_reg <= 1'b1;
					wdata_reg  <= s_axi_wdata;
					wstrb_reg  <= s_axi_wstrb;
				end
				if (bvalid_reg & s_axi_bready)
					bvalid_reg <= 1'b0;
			end
			if (do_read) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_word;
				rresp_reg  <= rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
			end else if (rvalid_reg & s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// Control, flag, mask and interrupt registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_CMP; i++)
				ctrl_reg[i] <= ACC_CTRL_RESET;
			flag_reg     <= '0;
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			flag_en_reg  <= '0;
			pin_reg      <= '0;
			pin_oe_reg   <= '0;
		end else begin
			if (do_write & wr_lane0 & (wr_ctrl < NUM_CMP))
				ctrl_reg[wr_ctrl] <= wr_data[7:0];
			if (do_write & wr_lane0 & (wr_addr == idx_addr(ACC_IDX_IRQMSK)))
				irq_mask_reg <= wr_data[NUM_CMP-1:0];
			if (do_write & wr_lane0 & (wr_addr == idx_addr(ACC_IDX_ENABLE)))
				flag_en_reg <= wr_data[NUM_CMP-1:0];
			flag_reg     <= flag_next;
			irq_stat_reg <= (irqst_read ? '0 : irq_stat_reg) | irq_set;
			pin_reg      <= pin_raw;
			pin_oe_reg   <= pin_oe_raw;
		end
	end

	a_flag_sets_on_event: assert property (@(posedge aclk) disable iff (!aresetn)
		event_pulse[0] |=> flag_reg[0])
		else $error("event did not set flag");
	a_flag_zero_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		(flag_wr && !flag_wdata[1] && !event_pulse[1]) |=> !flag_reg[1])
		else $error("flag write zero not cleared");
	a_flag_sim_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(flag_wr && flag_wdata[2]) |=> flag_reg[2])
		else $error("simulated event not set");
	a_status_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_read && rd_addr == idx_addr(ACC_IDX_STATUS)) |=> s_axi_rvalid && rdata_reg[31:NUM_CMP] == '0
			&& rdata_reg[NUM_CMP-1:0] == $past(result))
		else $error("status read wrong");
	a_pin_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_reg[0][ACC_BIT_PINEN] ##1 !ctrl_reg[0][ACC_BIT_PINEN] |-> !result_output_pin[0])
		else $error("pin driven while disabled");
	// Unmasked event raises the line one cycle later
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		(|(irq_set & irq_mask_reg)) && !(do_write && wr_lane0 && wr_addr == idx_addr(ACC_IDX_IRQMSK)) |=> irq)
		else $error("unmasked event did not raise irq");
	// Status read clears unless a new event lands in the same cycle
	a_irqst_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(irqst_read && !irq_set[0]) |=> !irq_stat_reg[0])
		else $error("irq status not cleared by read");

	// Bus answers one cycle after a request is taken
	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		do_read |=> s_axi_rvalid)
		else $error("read response missing");
	a_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && !wr_hit) |=> s_axi_bresp == ACC_RESP_SLVERR)
		else $error("unmapped write not refused");
	// No new request accepted on a channel while that channel's answer is pending
	a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during response");

	// Writes touch only their own control register, and only with lane 0
	a_ctrl_own_only: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && wr_lane0 && wr_ctrl == 0) |=> $stable(ctrl_reg[1]) && $stable(ctrl_reg[2]))
		else $error("control write leaked to another channel");
	a_lane_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && !wr_lane0) |=> $stable(ctrl_reg[0]) && $stable(ctrl_reg[1]) && $stable(ctrl_reg[2]))
		else $error("control changed without lane 0");
	// Pin enable stays low while the comparator is off
	a_pin_oe_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!comparator_on[0] ##1 !comparator_on[0] |-> !result_output_pin_oe[0])
		else $error("pin enabled while off");
endmodule
`default_nettype wire

// >>> testbench/acc_top_bench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_bench
	import acc_pkg::*;
;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic [ACC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0]           s_axi_wdata = '0;
	logic [3:0]            s_axi_wstrb = '0;
	logic [3:0]            wr_lanes = 4'h1;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic [31:0]           s_axi_rdata, d;
	logic [2:0]            raw_result = '0;
	logic [2:0]            result_output_pin, result_output_pin_oe, plus_input_source, comparator_on;
	logic [5:0]            minus_input_select;
	logic [1:0]            r;
	logic [7:0]            c;
	logic [7:0]            ctl [3];
	logic [31:0]           lf = 32'ha114;
	int                    n_fail = 0, samples_checked = 0, cycles = 0;
	localparam logic [13:0] FL = {ACC_IDX_FLAGS, 2'b00};
	localparam logic [13:0] ST = {ACC_IDX_STATUS, 2'b00};
	localparam logic [13:0] IS = {ACC_IDX_IRQST, 2'b00};

	acc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .raw_result, .result_output_pin,
		.result_output_pin_oe, .plus_input_source, .minus_input_select, .comparator_on, .irq);

	// Clock 20 MHz
	always #25 aclk = ~aclk;

	// Hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [13:0] ca(int k);
		return (k == 0) ? {ACC_IDX_CTRL1, 2'b00} : (k == 1) ? {ACC_IDX_CTRL2, 2'b00} : {ACC_IDX_CTRL3, 2'b00};
	endfunction

	// Polarity-adjusted results, zero while off
	function automatic logic [2:0] adj();
		logic [2:0] a;
		for (int k = 0; k < 3; k++) a[k] = ctl[k][7] & (raw_result[k] ^ ctl[k][5]);
		return a;
	endfunction

	// Expected pin, enable, source and select outputs
	function automatic logic [17:0] exp_pins();
		logic [2:0] on, pe, pl;
		logic [5:0] mi;
		for (int k = 0; k < 3; k++) begin
			on[k] = ctl[k][7];
			pe[k] = ctl[k][6];
			pl[k] = ctl[k][2];
			mi[2*k +: 2] = ctl[k][1:0];
		end
		return {adj() & pe, on & pe, pl, mi, on};
	endfunction

	function automatic logic ev(logic [1:0] m, logic nw);
		return m == 2'b11 || (m == 2'b01 && nw) || (m == 2'b10 && !nw);
	endfunction

	task automatic cyc(int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic chk(string n, logic [33:0] e, logic [33:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Write one byte register; handshakes judged just before each rising edge
	task automatic wr(logic [13:0] a, logic [7:0] v, logic [1:0] er);
		logic aw, w, b;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_wstrb <= wr_lanes;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = (s_axi_bvalid === 1'b1);
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		chk("bresp", {32'h0, er}, {32'h0, r});
	endtask

	task automatic axr(logic [13:0] a);
		logic ar, rv;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rv = 1'b0;
		while (!rv) begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			rv = (s_axi_rvalid === 1'b1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(string n, logic [13:0] a, logic [31:0] e, logic [1:0] er);
		axr(a);
		chk(n, {er, e}, {r, d});
	endtask

	task final_report;
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		for (int k = 0; k < 3; k++) ctl[k] = ACC_CTRL_RESET;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		raw_result <= lf[2:0];
		cyc(6);
		chk("irq", 34'h0, {33'h0, irq});
		chk("pins", {16'h0, exp_pins()}, {16'h0, result_output_pin, result_output_pin_oe, plus_input_source,
			minus_input_select, comparator_on});
		for (int k = 0; k < 3; k++) rd("ctrl", ca(k), 32'h1f, ACC_RESP_OKAY);
		rd("status", ST, 32'h0, ACC_RESP_OKAY);
		rd("unmapped", 14'h0, 32'h0, ACC_RESP_SLVERR);
		wr(14'h0, 8'hff, ACC_RESP_SLVERR);
		// A write with byte lane 0 off leaves the register alone
		wr_lanes = 4'he;
		wr(ca(1), 8'h00, ACC_RESP_OKAY);
		wr_lanes = 4'h1;
		rd("ctrl", ca(1), 32'h1f, ACC_RESP_OKAY);
		// Entering any-change mode raises the flag
		wr(ca(0), 8'h9f, ACC_RESP_OKAY);
		ctl[0] = 8'h9f;
		cyc(6);
		rd("flags", FL, 32'h20, ACC_RESP_OKAY);
		wr(FL, 8'h00, ACC_RESP_OKAY);
		rd("flags", FL, 32'h0, ACC_RESP_OKAY);
		wr(FL, 8'h80, ACC_RESP_OKAY);
		rd("flags", FL, 32'h80, ACC_RESP_OKAY);
		// Every comparator, edge mode, polarity and direction
		for (int i = 0; i < 3; i++) for (int m = 0; m < 4; m++) for (int q = 0; q < 4; q++) begin
			c = {1'b1, lf[0], q[0], m[1:0], lf[3:1]};
			lf = lfsr_next(lf);
			raw_result[i] <= q[1];
			wr(ca(i), c, ACC_RESP_OKAY);
			ctl[i] = c;
			cyc(6);
			wr(FL, 8'h00, ACC_RESP_OKAY);
			raw_result[i] <= !q[1];
			cyc(6);
			rd("flags", FL, 32'(ev(m[1:0], !q[1] ^ q[0])) << (ACC_FLAG_BASE + i), ACC_RESP_OKAY);
			rd("status", ST, {29'h0, adj()}, ACC_RESP_OKAY);
			chk("pins", {16'h0, exp_pins()}, {16'h0, result_output_pin, result_output_pin_oe, plus_input_source,
				minus_input_select, comparator_on});
			rd("ctrl", ca(i), {24'h0, c}, ACC_RESP_OKAY);
		end
		// Interrupt raised, masked and cleared by reading
		wr({ACC_IDX_ENABLE, 2'b00}, 8'h07, ACC_RESP_OKAY);
		wr({ACC_IDX_IRQMSK, 2'b00}, 8'h00, ACC_RESP_OKAY);
		wr(ca(0), 8'h98, ACC_RESP_OKAY);
		ctl[0] = 8'h98;
		cyc(6);
		axr(IS);
		raw_result[0] <= ~raw_result[0];
		cyc(6);
		chk("irq", 34'h0, {33'h0, irq});
		wr({ACC_IDX_IRQMSK, 2'b00}, 8'h01, ACC_RESP_OKAY);
		cyc(2);
		chk("irq", 34'h1, {33'h0, irq});
		rd("irqst", IS, 32'h1, ACC_RESP_OKAY);
		cyc(2);
		chk("irq", 34'h0, {33'h0, irq});
		rd("irqst", IS, 32'h0, ACC_RESP_OKAY);
		// Unmasked event raises the line
		raw_result[0] <= ~raw_result[0];
		cyc(6);
		chk("irq", 34'h1, {33'h0, irq});
		rd("irqst", IS, 32'h1, ACC_RESP_OKAY);
		rd("irqmsk", {ACC_IDX_IRQMSK, 2'b00}, 32'h1, ACC_RESP_OKAY);
		rd("flagen", {ACC_IDX_ENABLE, 2'b00}, 32'h7, ACC_RESP_OKAY);
		// Switching off forces result and pin enable low, inversion not applied
		wr(ca(0), 8'h78, ACC_RESP_OKAY);
		ctl[0] = 8'h78;
		cyc(6);
		rd("status", ST, {29'h0, adj()}, ACC_RESP_OKAY);
		chk("pins", {16'h0, exp_pins()}, {16'h0, result_output_pin, result_output_pin_oe, plus_input_source,
			minus_input_select, comparator_on});
		final_report();
	end
endmodule
`default_nettype wire
